// >>> spcr_defs.svh
`ifndef SPCR_DEFS_SVH
`define SPCR_DEFS_SVH

// ----------------------------------------
// Register offsets
// ----------------------------------------
`define SPCR_ADDR_CONFIG 10'h000
`define SPCR_ADDR_VARIANT 10'h003
`define SPCR_ADDR_RDBACK 10'h004

// ----------------------------------------
// Field positions
// ----------------------------------------
`define SPCR_BIT_FOUR_WIRE 0
`define SPCR_BIT_LSB_FIRST 1
`define SPCR_BIT_SOFT_RST 2
`define SPCR_BIT_LONG_INSTR 3
`define SPCR_BIT_RDBACK_ACT 0

// ----------------------------------------
// Reset values and masks
// ----------------------------------------
`define SPCR_RST_CONFIG 8'h18
`define SPCR_RST_RDBACK 8'h00
`define SPCR_KEEP_CONFIG 8'h04
`define SPCR_KEEP_NONE 8'h00
`define SPCR_RD_UNMAPPED 8'h00

`endif

// >>> spcr_pkg.sv
package spcr_pkg;
    // Register address as seen by the frame engine
    typedef logic [9:0] spcr_addr_t;
    // One register byte
    typedef logic [7:0] spcr_byte_t;
    // Which copy a readback returns
    typedef enum logic [0:0]
    {
        SPCR_BANK_BUFFER = 1'b0,
        SPCR_BANK_ACTIVE = 1'b1
    } spcr_bank_t;
endpackage

// >>> spcr_shadow_reg.sv
`timescale 1ns/1ps
// Buffered and active copy of one register byte
module spcr_shadow_reg
#(
    parameter spcr_pkg::spcr_byte_t RESET_VAL = 8'h00,
    parameter spcr_pkg::spcr_byte_t KEEP_MASK = 8'h00
)
(
    input wire logic core_clk,
    input wire logic rst_b,
    input wire logic wr_en,
    input wire spcr_pkg::spcr_byte_t wr_data,
    input wire logic update,
    input wire logic soft_rst,
    output spcr_pkg::spcr_byte_t buf_q,
    output spcr_pkg::spcr_byte_t act_q
);
    import spcr_pkg::*;

    spcr_byte_t buf_d; // Next buffered value
    spcr_byte_t act_d; // Next active value

    // ----------------------------------------
    // Next-value logic
    // ----------------------------------------
    always_comb
    begin
        buf_d = buf_q;
        act_d = act_q;
        if (wr_en)
        begin
            // Serial write lands in buffer only
            buf_d = wr_data;
        end
        else if (soft_rst)
        begin
            // Defaults, keeping the masked bits
            buf_d = (buf_q & KEEP_MASK) | (RESET_VAL & ~KEEP_MASK);
        end
        if (soft_rst)
        begin
            // Active copy back to defaults
            act_d = RESET_VAL;
        end
        else if (update)
        begin
            // Transfer buffered contents
            act_d = buf_q;
        end
    end

    // ----------------------------------------
    // Registers
    // ----------------------------------------
    always_ff @(posedge core_clk)
    begin
        if (!rst_b)
        begin
            buf_q <= RESET_VAL;
            act_q <= RESET_VAL;
        end
        else
        begin
            buf_q <= buf_d;
            act_q <= act_d;
        end
    end
endmodule

// >>> spcr_config_regs.sv
`timescale 1ns/1ps
`include "spcr_defs.svh"
// Serial port configuration, identifier and readback select
module spcr_config_regs
#(
    parameter logic [7:0] VARIANT_ID = 8'h5A // Arbitrary value
)
(
    input wire logic core_clk,
    input wire logic rst_b,
    input wire logic reg_wr_en,
    input wire spcr_pkg::spcr_addr_t reg_addr,
    input wire spcr_pkg::spcr_byte_t reg_wr_data,
    input wire logic reg_rd_en,
    input wire logic update_regs,
    input wire logic rd_bit,
    input wire logic rd_drive,
    output spcr_pkg::spcr_byte_t reg_rd_data_q,
    output logic lsb_first,
    output logic addr_incr,
    output logic long_instruction,
    output logic four_wire_select,
    output logic soft_reset_active,
    output logic mirror_err,
    output logic instr_mode_err,
    output logic serial_output_pin_out,
    output logic serial_output_pin_oe_b,
    output logic sdio_out,
    output logic sdio_oe_b
);
    import spcr_pkg::*;

    // ----------------------------------------
    // Functions
    // ----------------------------------------
    // Address match, used for write and read decode
    function automatic logic addr_is(input spcr_addr_t a, input spcr_addr_t b);
        addr_is = (a == b);
    endfunction

    // True when upper nibble mirrors lower nibble
    function automatic logic is_mirrored(input spcr_byte_t v);
        is_mirrored = (v[7] == v[0]) && (v[6] == v[1]) && (v[5] == v[2]) && (v[4] == v[3]);
    endfunction

    // ----------------------------------------
    // Register copies
    // ----------------------------------------
    spcr_byte_t cfg_buf; // Buffered configuration
    spcr_byte_t cfg_act; // Active configuration
    spcr_byte_t rdb_buf; // Buffered readback select
    spcr_byte_t rdb_act; // Active readback select
    logic soft_rst; // Soft reset in force
    logic cfg_wr; // Configuration write strobe
    logic rdb_wr; // Readback select write strobe
    spcr_bank_t bank_sel; // Copy chosen for readback

    // Soft reset acts straight from the buffered bit
    assign soft_rst = cfg_buf[`SPCR_BIT_SOFT_RST];
    // Config stays writable so the host can clear soft reset
    assign cfg_wr = reg_wr_en && addr_is(reg_addr, `SPCR_ADDR_CONFIG);
    // Other registers are frozen at defaults during soft reset
    assign rdb_wr = reg_wr_en && !soft_rst && addr_is(reg_addr, `SPCR_ADDR_RDBACK);
    assign bank_sel = spcr_bank_t'(rdb_act[`SPCR_BIT_RDBACK_ACT]);

    // Configuration byte, soft reset bit survives its own reset
    spcr_shadow_reg #(
        .RESET_VAL(`SPCR_RST_CONFIG),
        .KEEP_MASK(`SPCR_KEEP_CONFIG)
    ) u_cfg (
        .core_clk(core_clk),
        .rst_b(rst_b),
        .wr_en(cfg_wr),
        .wr_data(reg_wr_data),
        .update(update_regs),
        .soft_rst(soft_rst),
        .buf_q(cfg_buf),
        .act_q(cfg_act)
    );

    // Readback bank select
    spcr_shadow_reg #(
        .RESET_VAL(`SPCR_RST_RDBACK),
        .KEEP_MASK(`SPCR_KEEP_NONE)
    ) u_rdb (
        .core_clk(core_clk),
        .rst_b(rst_b),
        .wr_en(rdb_wr),
        .wr_data(reg_wr_data),
        .update(update_regs),
        .soft_rst(soft_rst),
        .buf_q(rdb_buf),
        .act_q(rdb_act)
    );

    // ----------------------------------------
    // Mode outputs from the active copy, soft reset flag from the buffered bit
    // ----------------------------------------
    assign lsb_first = cfg_act[`SPCR_BIT_LSB_FIRST];
    assign addr_incr = cfg_act[`SPCR_BIT_LSB_FIRST];
    assign long_instruction = cfg_act[`SPCR_BIT_LONG_INSTR];
    assign four_wire_select = cfg_act[`SPCR_BIT_FOUR_WIRE];
    assign soft_reset_active = soft_rst;
    // Flags a host that broke the mirror convention
    assign mirror_err = !is_mirrored(cfg_act);
    // Short instructions are unsupported here
    assign instr_mode_err = !cfg_act[`SPCR_BIT_LONG_INSTR];

    // ----------------------------------------
    // Readback path
    // ----------------------------------------
    spcr_byte_t rd_data_d; // Next read data
    logic opin_d; // Next output pin data
    logic opin_oe_b_d; // Next output pin enable
    logic sdio_d; // Next data pin value
    logic sdio_oe_b_d; // Next data pin enable

    // Read mux and pin steering
    always_comb
    begin
        rd_data_d = reg_rd_data_q;
        if (reg_rd_en)
        begin
            if (addr_is(reg_addr, `SPCR_ADDR_CONFIG))
            begin
                // Buffered or active copy per select
                rd_data_d = (bank_sel == SPCR_BANK_ACTIVE) ? cfg_act : cfg_buf;
            end
            else if (addr_is(reg_addr, `SPCR_ADDR_VARIANT))
            begin
                // Constant identifier, no reset path
                rd_data_d = VARIANT_ID;
            end
            else if (addr_is(reg_addr, `SPCR_ADDR_RDBACK))
            begin
                rd_data_d = (bank_sel == SPCR_BANK_ACTIVE) ? rdb_act : rdb_buf;
            end
            else
            begin
                // Unmapped here
                rd_data_d = `SPCR_RD_UNMAPPED;
            end
        end
        // Four-wire: output pin reads, data pin stays input
        opin_d = rd_bit;
        sdio_d = rd_bit;
        opin_oe_b_d = !(rd_drive && four_wire_select);
        sdio_oe_b_d = !(rd_drive && !four_wire_select);
    end

    // Output registers
    always_ff @(posedge core_clk)
    begin
        if (!rst_b)
        begin
            reg_rd_data_q <= 8'h00;
            serial_output_pin_out <= 1'b0;
            serial_output_pin_oe_b <= 1'b1;
            sdio_out <= 1'b0;
            sdio_oe_b <= 1'b1;
        end
        else
        begin
            reg_rd_data_q <= rd_data_d;
            serial_output_pin_out <= opin_d;
            serial_output_pin_oe_b <= opin_oe_b_d;
            sdio_out <= sdio_d;
            sdio_oe_b <= sdio_oe_b_d;
        end
    end

    // ----------------------------------------
    // Assertions
    // ----------------------------------------
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rst_b);

    variant_read_a: assert property (
        reg_rd_en && addr_is(reg_addr, `SPCR_ADDR_VARIANT) |=> reg_rd_data_q == VARIANT_ID)
        else $error("identifier read wrong");
    variant_nowrite_a: assert property (
        reg_wr_en && addr_is(reg_addr, `SPCR_ADDR_VARIANT) ##1
        reg_rd_en && addr_is(reg_addr, `SPCR_ADDR_VARIANT) |=> reg_rd_data_q == VARIANT_ID)
        else $error("identifier changed by write");
    soft_set_a: assert property (
        cfg_wr && reg_wr_data[`SPCR_BIT_SOFT_RST] |=> soft_reset_active ##1 rdb_act == 8'h00)
        else $error("soft reset not applied");
    soft_sticky_a: assert property (
        soft_reset_active && !cfg_wr |=> soft_reset_active)
        else $error("soft reset cleared itself");
    soft_clear_a: assert property (
        cfg_wr && !reg_wr_data[`SPCR_BIT_SOFT_RST] |=> !soft_reset_active)
        else $error("soft reset not released");
    buf_only_a: assert property (
        cfg_wr && !update_regs && !soft_rst |=> cfg_act == $past(cfg_act))
        else $error("write reached active copy");
    update_copy_a: assert property (
        update_regs && !soft_rst |=> cfg_act == $past(cfg_buf))
        else $error("update did not transfer");
    bank_pick_a: assert property (
        reg_rd_en && addr_is(reg_addr, `SPCR_ADDR_CONFIG) |=>
        reg_rd_data_q == ($past(rdb_act[0]) ? $past(cfg_act) : $past(cfg_buf)))
        else $error("readback bank wrong");
    step_dir_a: assert property (
        update_regs && !soft_rst |=>
        addr_incr == $past(cfg_buf[`SPCR_BIT_LSB_FIRST]) && lsb_first == addr_incr)
        else $error("address step disagrees with order");
    opin_hiz_a: assert property (
        !four_wire_select |=> serial_output_pin_oe_b)
        else $error("output pin driven in three-wire mode");
    sdio_hold_a: assert property (
        four_wire_select && rd_drive |=> sdio_oe_b && !serial_output_pin_oe_b)
        else $error("data pin driven in four-wire read");
    long_flag_a: assert property (
        update_regs && !soft_rst |=>
        instr_mode_err == !$past(cfg_buf[`SPCR_BIT_LONG_INSTR]) &&
        long_instruction == $past(cfg_buf[`SPCR_BIT_LONG_INSTR]))
        else $error("instruction mode flag wrong");

    soft_cycle_c: cover property (
        cfg_wr && reg_wr_data[`SPCR_BIT_SOFT_RST] ##[1:20] cfg_wr && !reg_wr_data[2]);
    active_read_c: cover property (
        bank_sel == SPCR_BANK_ACTIVE && reg_rd_en && addr_is(reg_addr, `SPCR_ADDR_CONFIG));
    four_wire_read_c: cover property (four_wire_select && rd_drive);
    update_c: cover property (update_regs && cfg_buf != cfg_act);
endmodule

// >>> spcr_host_model.sv
`timescale 1ns/1ps
// Host side of the register port: strobes, address, data and pin stimulus
module spcr_host_model
(
    input wire logic core_clk,
    input wire spcr_pkg::spcr_byte_t reg_rd_data_q,
    output logic reg_wr_en,
    output spcr_pkg::spcr_addr_t reg_addr,
    output spcr_pkg::spcr_byte_t reg_wr_data,
    output logic reg_rd_en,
    output logic update_regs,
    output logic rd_bit,
    output logic rd_drive
);
    import spcr_pkg::*;
    // ----------------------------------------
    // Idle levels
    // ----------------------------------------
    initial
    begin
        {reg_wr_en, reg_rd_en, update_regs, rd_bit, rd_drive} = 5'h00;
        reg_addr = 10'h000;
        reg_wr_data = 8'h00;
    end
    // Upper nibble as bit-reversed lower nibble
    function automatic spcr_byte_t mirror(input logic [3:0] n);
        return {n[0], n[1], n[2], n[3], n};
    endfunction
    // One byte write; released lines show the inverse
    task automatic wr(input spcr_addr_t a, input spcr_byte_t d);
        @(posedge core_clk);
        reg_wr_en <= 1'b1;
        reg_addr <= a;
        reg_wr_data <= d;
        @(posedge core_clk);
        reg_wr_en <= 1'b0;
        reg_addr <= ~a;
        reg_wr_data <= ~d;
        #1;
    endtask
    // Well-formed configuration byte, long instruction kept
    task automatic cfg(input logic [2:0] n);
        wr(10'h000, mirror({1'b1, n}));
    endtask
    // One byte read, data taken one cycle after the strobe
    task automatic rd(input spcr_addr_t a, output spcr_byte_t d);
        @(posedge core_clk);
        reg_rd_en <= 1'b1;
        reg_addr <= a;
        @(posedge core_clk);
        reg_rd_en <= 1'b0;
        reg_addr <= ~a;
        #1;
        d = reg_rd_data_q;
    endtask
    // Buffered to active transfer pulse
    task automatic upd();
        @(posedge core_clk);
        update_regs <= 1'b1;
        @(posedge core_clk);
        update_regs <= 1'b0;
        #1;
    endtask
    // Read phase level and bit
    task automatic pin(input logic d, input logic b);
        @(posedge core_clk);
        rd_drive <= d;
        rd_bit <= b;
        #1;
    endtask
    // Soft reset finished by writing the bit back to zero
    task automatic sreset_end();
        cfg(3'h0);
    endtask
endmodule

// >>> testbench.sv
`timescale 1ns/1ps
`include "spcr_defs.svh"
module testbench;
    import spcr_pkg::*;
    localparam spcr_byte_t VARIANT = 8'hA7; // Arbitrary value
    logic core_clk = 1'b0;
    logic rst_b = 1'b0;
    logic reg_wr_en, reg_rd_en, update_regs, rd_bit, rd_drive;
    spcr_addr_t reg_addr;
    spcr_byte_t reg_wr_data, reg_rd_data_q, d, buff, act;
    logic lsb_first, addr_incr, long_instruction, four_wire_select, soft_reset_active;
    logic mirror_err, instr_mode_err, serial_output_pin_out, serial_output_pin_oe_b;
    logic sdio_out, sdio_oe_b, sel_a, sel_b;
    int n_mismatch = 0;
    int total_checks = 0;
    int seed = 32'hE7A3A344;
    int r;
    logic [31:0] rnd; // Random draw for one pass
    spcr_addr_t r_addr[4] = '{10'h000, 10'h003, 10'h004, 10'h3FF};
    always #4 core_clk = ~core_clk;
    spcr_config_regs #(.VARIANT_ID(VARIANT)) i_spcr_config_regs (.core_clk(core_clk),
        .rst_b(rst_b), .reg_wr_en(reg_wr_en), .reg_addr(reg_addr),
        .reg_wr_data(reg_wr_data), .reg_rd_en(reg_rd_en), .update_regs(update_regs),
        .rd_bit(rd_bit), .rd_drive(rd_drive), .reg_rd_data_q(reg_rd_data_q),
        .lsb_first(lsb_first), .addr_incr(addr_incr), .long_instruction(long_instruction),
        .four_wire_select(four_wire_select), .soft_reset_active(soft_reset_active),
        .mirror_err(mirror_err), .instr_mode_err(instr_mode_err),
        .serial_output_pin_out(serial_output_pin_out),
        .serial_output_pin_oe_b(serial_output_pin_oe_b), .sdio_out(sdio_out),
        .sdio_oe_b(sdio_oe_b));
    spcr_host_model i_spcr_host_model (.core_clk(core_clk), .reg_rd_data_q(reg_rd_data_q),
        .reg_wr_en(reg_wr_en), .reg_addr(reg_addr), .reg_wr_data(reg_wr_data),
        .reg_rd_en(reg_rd_en), .update_regs(update_regs), .rd_bit(rd_bit),
        .rd_drive(rd_drive));
    // ----------------------------------------
    // Compare and report
    // ----------------------------------------
    task automatic chk_byte(input spcr_byte_t e, input spcr_byte_t g);
        total_checks++;
        if (g !== e)
        begin
            n_mismatch++;
            $display("CHECK FAILED t=%0t exp=%h got=%h", $time, e, g);
        end
    endtask
    task automatic chk_bit(input logic e, input logic g);
        total_checks++;
        if (g !== e)
        begin
            n_mismatch++;
            $display("CHECK FAILED t=%0t exp=%h got=%h", $time, e, g);
        end
    endtask
    task automatic print_verdict();
        $display("checks %0d mismatches %0d", total_checks, n_mismatch);
        if (n_mismatch == 0 && total_checks > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    // Expected readback from the tracked copies
    function automatic spcr_byte_t exp_rd(input spcr_addr_t a);
        if (a == `SPCR_ADDR_CONFIG)
            return sel_a ? act : buff;
        if (a == `SPCR_ADDR_VARIANT)
            return VARIANT;
        if (a == `SPCR_ADDR_RDBACK)
            return {7'h00, sel_a ? sel_a : sel_b};
        return 8'h00;
    endfunction
    task automatic rdchk(input spcr_addr_t a);
        i_spcr_host_model.rd(a, d);
        chk_byte(exp_rd(a), d);
    endtask
    task automatic chk_modes();
        chk_bit(act[1], lsb_first);
        chk_bit(act[1], addr_incr);
        chk_bit(act[0], four_wire_select);
        chk_bit(act[3], long_instruction);
        chk_bit(act[7:4] != {act[0], act[1], act[2], act[3]}, mirror_err);
        chk_bit(~act[3], instr_mode_err);
    endtask
    // Read phase on the pins, then idle with both pins released
    task automatic chk_pins(input logic b);
        i_spcr_host_model.pin(1'b1, b);
        @(posedge core_clk);
        #1;
        chk_bit(~act[0], serial_output_pin_oe_b);
        chk_bit(act[0], sdio_oe_b);
        chk_bit(b, serial_output_pin_out);
        chk_bit(b, sdio_out);
        i_spcr_host_model.pin(1'b0, ~b);
        @(posedge core_clk);
        #1;
        chk_bit(1'b1, serial_output_pin_oe_b & sdio_oe_b);
        chk_bit(~b, sdio_out);
    endtask
    // ----------------------------------------
    // Main sequence
    // ----------------------------------------
    initial
    begin
        repeat (10) @(posedge core_clk);
        rst_b <= 1'b1;
        #1;
        {buff, act, sel_a, sel_b} = {`SPCR_RST_CONFIG, `SPCR_RST_CONFIG, 2'b00};
        chk_modes();
        chk_bit(1'b0, soft_reset_active);
        foreach (r_addr[i])
            rdchk(r_addr[i]);
        chk_pins(1'b1);
        $display("test reset done");
        for (r = 0; r < 16; r++)
        begin
            rnd = $random(seed);
            buff = {rnd[0], rnd[1], 1'b0, 1'b1, 1'b1, 1'b0, rnd[1:0]};
            i_spcr_host_model.cfg({1'b0, rnd[1:0]});
            sel_b = rnd[4];
            i_spcr_host_model.wr(`SPCR_ADDR_RDBACK, {7'h00, sel_b});
            i_spcr_host_model.wr(`SPCR_ADDR_VARIANT, rnd[15:8]);
            chk_modes();
            rdchk(`SPCR_ADDR_CONFIG);
            i_spcr_host_model.upd();
            {act, sel_a} = {buff, sel_b};
            chk_modes();
            rdchk(`SPCR_ADDR_RDBACK);
            rdchk(`SPCR_ADDR_VARIANT);
            rdchk({2'b00, rnd[23:16]});
            chk_pins(rnd[7]);
        end
        $display("test random done");
        // Broken mirror, then short instruction: stored and only flagged
        i_spcr_host_model.wr(`SPCR_ADDR_CONFIG, 8'h0A);
        i_spcr_host_model.upd();
        {buff, act} = {8'h0A, 8'h0A};
        chk_modes();
        i_spcr_host_model.wr(`SPCR_ADDR_CONFIG, 8'h42);
        i_spcr_host_model.wr(`SPCR_ADDR_RDBACK, 8'h01);
        i_spcr_host_model.upd();
        {buff, act, sel_a, sel_b} = {8'h42, 8'h42, 2'b11};
        chk_modes();
        rdchk(`SPCR_ADDR_CONFIG);
        // Soft reset: defaults, select write refused, update ignored
        i_spcr_host_model.wr(`SPCR_ADDR_CONFIG, 8'h3C);
        i_spcr_host_model.wr(`SPCR_ADDR_RDBACK, 8'h01);
        i_spcr_host_model.upd();
        {buff, act, sel_a, sel_b} = {8'h1C, `SPCR_RST_CONFIG, 2'b00};
        chk_bit(1'b1, soft_reset_active);
        chk_modes();
        foreach (r_addr[i])
            rdchk(r_addr[i]);
        i_spcr_host_model.sreset_end();
        buff = `SPCR_RST_CONFIG;
        chk_bit(1'b0, soft_reset_active);
        rdchk(`SPCR_ADDR_CONFIG);
        i_spcr_host_model.upd();
        chk_modes();
        $display("test soft reset done");
        print_verdict();
    end
    // Watchdog against a hang
    initial
    begin
        #(20000 * 8);
        n_mismatch++;
        print_verdict();
    end
endmodule
